// >>> hci_spi_consts.svh
// Named constants of the serial host transport port
`ifndef HCI_SPI_CONSTS_SVH
`define HCI_SPI_CONSTS_SVH

`define SPI_BYTE_W 8
`define SPI_BIT_CNT_W 3
`define SPI_BIT_FIRST 3'h0
`define SPI_BIT_LAST 3'h7
`define SPI_FILL_BYTE 8'h00
`define SPI_BUF_DEPTH 1040
`define SPI_STRAP_SEL_LEVEL 1'b0
`define SPI_STRAP_CNT_W 2
`define SPI_STRAP_SETTLE 2'h3
`define SPI_SYNC_W 3

`endif

// >>> hci_spi_pkg.sv
// Types shared by the serial host transport port
`default_nettype none
package hci_spi_pkg;
  typedef struct packed {
    logic cs_active_high;
    logic attn_active_high;
    logic lsb_first;
  } spi_cfg_t;

  typedef struct packed {
    logic miso;
    logic miso_oe;
    logic attn;
  } spi_pins_out_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XFER,
    ST_ASLEEP
  } link_state_t;
endpackage
`default_nettype wire

// >>> hci_spi_fifo.sv
// Byte FIFO with registered read port and valid/ready on both sides
`default_nettype none
module hci_spi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1040
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic in_ready_reg, in_ready_next, out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg;
  logic push, load;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : p + AW'(1);
  endfunction

  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always_comb begin
    push = in_valid & in_ready_reg;
    load = (cnt_reg != '0) & (~out_valid_reg | out_ready);
    wptr_next = push ? ptr_inc(wptr_reg) : wptr_reg;
    rptr_next = load ? ptr_inc(rptr_reg) : rptr_reg;
    cnt_next = cnt_reg + CW'(push) - CW'(load);
    // Ready is kept in a register so the port output comes from a flop
    in_ready_next = (cnt_next != FULL_CNT);
    out_valid_next = load | (out_valid_reg & ~out_ready);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      in_ready_reg <= 1'b1;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
      in_ready_reg <= in_ready_next;
      out_valid_reg <= out_valid_next;
      if (load) begin
        out_data_reg <= mem[rptr_reg];
      end
    end
  end

  // Storage carries no reset
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// >>> hci_spi_slave_transport.sv
// Serial slave port that carries the host transport, with packet buffers both ways
// Operation
// R1: The port is only a slave and follows any master clock up to 16 MHz.
// R2: A setting chooses whether chip select is active low or active high.
// R3: A setting chooses whether the attention output is active low or active high.
// R4: A setting chooses lsb-first or msb-first order on both data lines.
// R5: Each transaction starts only after attention has announced it to the master; the port starts a transfer on any chip select, with or without attention.
// R6: A running payload is never paused and the buffers hold a whole largest packet.
// R7: Only the master halts bytes, by dropping chip select or stopping its clock.
// R8: Flow control belongs to higher layers, not to the serial link.
// R9: Sleep entry and exit are agreed by a half-duplex handshake over the link; the port instead sleeps and wakes on sleep_request or chip select.
// R10: Each direction buffers 1040 bytes.
// R11: The port is the host transport only when the strap line reads zero at boot.
// R12: With chip select inactive, clock and input are ignored and the output floats.
// R13: Input is sampled on rising clock edges, output changes on falling edges, attention marks pending data.
`include "hci_spi_consts.svh"
`default_nettype none
module hci_spi_slave_transport #(
  parameter int BUF_DEPTH = `SPI_BUF_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Configuration and boot strap
  input wire hci_spi_pkg::spi_cfg_t cfg,
  input wire logic strap_sel,
  // Serial link pins
  input wire logic transport_chip_select,
  input wire logic link_sclk,
  input wire logic link_mosi,
  output hci_spi_pkg::spi_pins_out_t pins,
  // Sleep handshake
  input wire logic sleep_request,
  output logic link_asleep,
  output logic spi_selected,
  // Received bytes toward the host stack
  output logic rx_valid,
  output logic [`SPI_BYTE_W-1:0] rx_data,
  input wire logic rx_ready,
  output logic rx_overrun,
  // Bytes to send to the master
  input wire logic tx_valid,
  input wire logic [`SPI_BYTE_W-1:0] tx_data,
  output logic tx_ready
);
  import hci_spi_pkg::*;

  logic [`SPI_SYNC_W-1:0] sck_sy, cs_sy, si_sy, strap_sy;
  logic sck_st_reg, sck_st_next, cs_st_reg, cs_st_next, si_st_reg, si_st_next;
  logic [`SPI_STRAP_CNT_W-1:0] strap_cnt_reg, strap_cnt_next;
  logic sel_reg, sel_next, caught_reg, caught_next;
  link_state_t state_reg, state_next;
  logic [`SPI_BIT_CNT_W-1:0] bit_reg, bit_next;
  logic [`SPI_BYTE_W-1:0] rx_sh_reg, rx_sh_next, tx_byte_reg, tx_byte_next;
  spi_pins_out_t pins_reg, pins_next;
  logic asleep_reg, asleep_next, ovr_reg, ovr_next;
  logic rise, fall, active, attn_on, tx_pop, rx_push, rx_in_ready, tx_out_valid;
  logic [`SPI_BYTE_W-1:0] tx_out_data, fetch;

  // Bit of a byte at a given position on the wire
  function automatic logic wire_bit(input logic [`SPI_BYTE_W-1:0] b,
                                    input logic [`SPI_BIT_CNT_W-1:0] idx,
                                    input logic lsb);
    wire_bit = lsb ? b[idx] : b[`SPI_BIT_LAST - idx];
  endfunction

  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sck_sy <= '0;
      cs_sy <= '0;
      si_sy <= '0;
      strap_sy <= '0;
    end else begin
      sck_sy <= {sck_sy[1:0], link_sclk}; // [R1]
      cs_sy <= {cs_sy[1:0], transport_chip_select};
      si_sy <= {si_sy[1:0], link_mosi};
      strap_sy <= {strap_sy[1:0], strap_sel};
    end
  end

  always_comb begin
    sck_st_next = (sck_sy[1] == sck_sy[2]) ? sck_sy[2] : sck_st_reg;
    cs_st_next = (cs_sy[1] == cs_sy[2]) ? cs_sy[2] : cs_st_reg;
    si_st_next = (si_sy[1] == si_sy[2]) ? si_sy[2] : si_st_reg;
    rise = sck_st_next & ~sck_st_reg; // [R13]
    fall = ~sck_st_next & sck_st_reg; // [R13]
    // Strap is caught once, after its synchroniser has filled and settled
    strap_cnt_next = strap_cnt_reg;
    sel_next = sel_reg;
    caught_next = caught_reg;
    if (strap_cnt_reg != `SPI_STRAP_SETTLE) begin
      strap_cnt_next = strap_cnt_reg + `SPI_STRAP_CNT_W'(1);
    end else if (!caught_reg && (strap_sy[1] == strap_sy[2])) begin
      caught_next = 1'b1;
      sel_next = (strap_sy[2] == `SPI_STRAP_SEL_LEVEL); // [R11]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sck_st_reg <= 1'b0;
      cs_st_reg <= 1'b0;
      si_st_reg <= 1'b0;
      strap_cnt_reg <= '0;
      sel_reg <= 1'b0;
      caught_reg <= 1'b0;
    end else begin
      sck_st_reg <= sck_st_next;
      cs_st_reg <= cs_st_next;
      si_st_reg <= si_st_next;
      strap_cnt_reg <= strap_cnt_next;
      sel_reg <= sel_next;
      caught_reg <= caught_next;
    end
  end

  // Link engine
  always_comb begin
    active = sel_reg & (cfg.cs_active_high ? cs_st_next : ~cs_st_next); // [R2] [R12]
    state_next = state_reg;
    bit_next = bit_reg;
    rx_sh_next = rx_sh_reg;
    tx_byte_next = tx_byte_reg;
    pins_next = pins_reg;
    asleep_next = asleep_reg;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    ovr_next = 1'b0;
    fetch = tx_out_valid ? tx_out_data : `SPI_FILL_BYTE;
    unique case (state_reg)
      ST_ASLEEP: begin
        // Master selecting the port or firmware withdrawing the request wakes it
        if (active || !sleep_request) begin // [R9]
          state_next = ST_IDLE;
          asleep_next = 1'b0;
        end
      end
      ST_IDLE: begin
        if (active) begin
          state_next = ST_XFER;
          bit_next = `SPI_BIT_FIRST;
          tx_byte_next = fetch;
          tx_pop = tx_out_valid;
          pins_next.miso = wire_bit(fetch, `SPI_BIT_FIRST, cfg.lsb_first); // [R4]
          pins_next.miso_oe = 1'b1;
        end else if (sleep_request && !tx_out_valid) begin
          state_next = ST_ASLEEP; // [R9]
          asleep_next = 1'b1;
        end
      end
      ST_XFER: begin
        if (!active) begin
          // Master ends the frame; a partial byte is dropped
          state_next = ST_IDLE; // [R7]
          pins_next.miso_oe = 1'b0; // [R12]
        end else if (rise) begin
          rx_sh_next = cfg.lsb_first ? {si_st_next, rx_sh_reg[`SPI_BYTE_W-1:1]}
                                     : {rx_sh_reg[`SPI_BYTE_W-2:0], si_st_next}; // [R4] [R13]
          bit_next = bit_reg + `SPI_BIT_CNT_W'(1);
          if (bit_reg == `SPI_BIT_LAST) begin
            rx_push = 1'b1; // [R6]
            // No link stall on a full buffer; the loss is only reported
            ovr_next = ~rx_in_ready; // [R8]
          end
        end else if (fall) begin
          if (bit_reg == `SPI_BIT_FIRST) begin
            // Next byte is taken without stalling; an empty buffer sends fill
            tx_byte_next = fetch; // [R6]
            tx_pop = tx_out_valid;
            pins_next.miso = wire_bit(fetch, `SPI_BIT_FIRST, cfg.lsb_first); // [R13]
          end else begin
            pins_next.miso = wire_bit(tx_byte_reg, bit_reg, cfg.lsb_first); // [R4] [R13]
          end
        end
      end
    endcase
    // Attention announces pending output before the master may start
    attn_on = sel_reg & tx_out_valid & (state_next != ST_ASLEEP); // [R5] [R13]
    pins_next.attn = cfg.attn_active_high ? attn_on : ~attn_on; // [R3]
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      bit_reg <= '0;
      rx_sh_reg <= '0;
      tx_byte_reg <= '0;
      pins_reg <= '0;
      asleep_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      rx_sh_reg <= rx_sh_next;
      tx_byte_reg <= tx_byte_next;
      pins_reg <= pins_next;
      asleep_reg <= asleep_next;
      ovr_reg <= ovr_next;
    end
  end

  // Whole-packet buffers in both directions
  hci_spi_fifo #(.WIDTH(`SPI_BYTE_W), .DEPTH(BUF_DEPTH)) u_rx_buf ( // [R10]
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(rx_push),
    .in_data(rx_sh_next),
    .in_ready(rx_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  hci_spi_fifo #(.WIDTH(`SPI_BYTE_W), .DEPTH(BUF_DEPTH)) u_tx_buf ( // [R10]
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(tx_out_valid),
    .out_data(tx_out_data),
    .out_ready(tx_pop)
  );

  assign pins = pins_reg;
  assign link_asleep = asleep_reg;
  assign spi_selected = sel_reg;
  assign rx_overrun = ovr_reg;
endmodule
`default_nettype wire

// >>> hci_spi_slave_transport_properties.sv
// Concurrent checks on the serial host transport port
`include "hci_spi_consts.svh"
`default_nettype none
module hci_spi_slave_transport_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Configuration and link pins
  input wire hci_spi_pkg::spi_cfg_t cfg,
  input wire logic strap_sel,
  input wire logic transport_chip_select,
  input wire logic link_sclk,
  input wire logic link_mosi,
  input wire hci_spi_pkg::spi_pins_out_t pins,
  // Sleep and streams
  input wire logic sleep_request,
  input wire logic link_asleep,
  input wire logic spi_selected,
  input wire logic rx_valid,
  input wire logic [`SPI_BYTE_W-1:0] rx_data,
  input wire logic rx_ready,
  input wire logic rx_overrun,
  input wire logic tx_valid,
  input wire logic [`SPI_BYTE_W-1:0] tx_data,
  input wire logic tx_ready
);
  import hci_spi_pkg::*;
  wire logic cs_act = (transport_chip_select == cfg.cs_active_high);
  wire logic attn_act = (pins.attn == cfg.attn_active_high);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_idle_float; !cs_act [*6] |-> !pins.miso_oe; endproperty
  a_idle_float: assert property (p_idle_float) else $error("miso driven while idle");
  property p_strap_off; !spi_selected |-> !pins.miso_oe; endproperty
  a_strap_off: assert property (p_strap_off) else $error("miso driven unselected");
  property p_asleep_quiet; link_asleep |-> !attn_act; endproperty
  a_asleep_quiet: assert property (p_asleep_quiet) else $error("attn while asleep");
  property p_attn_rise;
    tx_valid && tx_ready && !cs_act && !sleep_request && !link_asleep |-> ##[1:4] attn_act;
  endproperty
  a_attn_rise: assert property (p_attn_rise) else $error("attn late");
  property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx byte lost");
  property p_sleep_in; (sleep_request && !cs_act && !attn_act && !tx_valid) [*8] |-> link_asleep;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("no sleep entry");
  property p_sleep_out; link_asleep && !sleep_request |-> ##[1:2] !link_asleep; endproperty
  a_sleep_out: assert property (p_sleep_out) else $error("no sleep exit");
  property p_miso_hold;
    link_sclk [*4] ##0 (pins.miso_oe && $past(pins.miso_oe)) |-> $stable(pins.miso);
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved in high phase");
  c_asleep: cover property (link_asleep);
  c_overrun: cover property (rx_overrun);
  c_take: cover property (rx_valid && rx_ready);
endmodule
bind hci_spi_slave_transport hci_spi_slave_transport_properties u_props (
  .mclk(mclk),
  .rst_b(rst_b),
  .cfg(cfg),
  .strap_sel(strap_sel),
  .transport_chip_select(transport_chip_select),
  .link_sclk(link_sclk),
  .link_mosi(link_mosi),
  .pins(pins),
  .sleep_request(sleep_request),
  .link_asleep(link_asleep),
  .spi_selected(spi_selected),
  .rx_valid(rx_valid),
  .rx_data(rx_data),
  .rx_ready(rx_ready),
  .rx_overrun(rx_overrun),
  .tx_valid(tx_valid),
  .tx_data(tx_data),
  .tx_ready(tx_ready)
);
`default_nettype wire

// >>> spi_master_model.sv
// Behavioural serial master that drives frames into the transport port
`default_nettype none
module spi_master_model (
  // Polarity and bit order
  input wire hci_spi_pkg::spi_cfg_t cfg,
  // Serial lines
  output logic transport_chip_select,
  output logic link_sclk,
  output logic link_mosi,
  input wire logic miso_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sel = 1'b0;
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  assign transport_chip_select = cfg.cs_active_high ? sel : !sel;
  initial begin
    link_sclk = 1'b0;
    link_mosi = 1'b0;
  end
  // Clock runs only in frames at 80 ns; miso is read late in the high phase
  task automatic frame(input int n);
    logic [7:0] b;
    logic [7:0] r;
    rx_q = {};
    #3 sel = 1'b1;
    #100;
    for (int j = 0; j < n; j++) begin
      b = tx_q.pop_front();
      for (int k = 0; k < 8; k++) begin
        link_mosi = b[cfg.lsb_first ? k : 7 - k];
        #40 link_sclk = 1'b1;
        #38 r[cfg.lsb_first ? k : 7 - k] = miso_line;
        #2 link_sclk = 1'b0;
      end
      rx_q.push_back(r);
    end
    #40 sel = 1'b0;
    link_mosi = !link_mosi;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench of the serial host transport port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hci_spi_pkg::*;
  logic mclk, rst_b, strap_sel, sleep_request, rx_ready, tx_valid, miso_last;
  logic transport_chip_select, link_sclk, link_mosi, link_asleep, spi_selected;
  logic rx_valid, rx_overrun, tx_ready;
  logic [7:0] rx_data, tx_data;
  spi_cfg_t cfg;
  spi_pins_out_t pins;
  int miscompares, n_tests, ovr;
  // Released miso floats: model it as the inverse of the last driven bit
  wire logic miso_line = pins.miso_oe ? pins.miso : !miso_last;
  hci_spi_slave_transport #(.BUF_DEPTH(4)) u_hci_spi_slave_transport (
    .mclk(mclk),
    .rst_b(rst_b),
    .cfg(cfg),
    .strap_sel(strap_sel),
    .transport_chip_select(transport_chip_select),
    .link_sclk(link_sclk),
    .link_mosi(link_mosi),
    .pins(pins),
    .sleep_request(sleep_request),
    .link_asleep(link_asleep),
    .spi_selected(spi_selected),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ready(rx_ready),
    .rx_overrun(rx_overrun),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready)
  );
  spi_master_model u_spi_master_model (
    .cfg(cfg),
    .transport_chip_select(transport_chip_select),
    .link_sclk(link_sclk),
    .link_mosi(link_mosi),
    .miso_line(miso_line)
  );
  initial begin
    mclk = 1'b0;
    forever #5 mclk = !mclk;
  end
  always @(posedge mclk) begin
    if (pins.miso_oe) miso_last <= pins.miso;
    if (rx_overrun === 1'b1) ovr <= ovr + 1;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic restart(input spi_cfg_t c, input logic s);
    rst_b = 1'b0;
    cfg = c;
    strap_sel = s;
    cyc(5);
    rst_b = 1'b1;
    cyc(8);
  endtask
  task automatic push(input logic [7:0] d, output logic took);
    tx_valid = 1'b1;
    tx_data = d;
    took = tx_ready;
    cyc(1);
  endtask
  task automatic pull(input logic [7:0] exp);
    int i;
    cyc(1);
    for (i = 0; i < 20 && rx_valid !== 1'b1; i++) cyc(1);
    if (i == 20) begin
      miscompares++;
      summarize();
    end
    chk("rx_data", exp, rx_data);
    rx_ready = 1'b1;
    cyc(1);
    rx_ready = 1'b0;
  endtask
  task automatic t_modes();
    spi_cfg_t c;
    logic t;
    for (int m = 0; m < 8; m++) begin
      c = spi_cfg_t'(m[2:0]);
      restart(c, 1'b0);
      chk("selected", 8'h01, {7'h00, spi_selected});
      chk("attn idle", {7'h00, !c.attn_active_high}, {7'h00, pins.attn});
      push(8'h31 + 8'(m), t);
      push(8'h84, t);
      tx_valid = 1'b0;
      cyc(4);
      chk("attn set", {7'h00, c.attn_active_high}, {7'h00, pins.attn});
      u_spi_master_model.tx_q = {8'h1e, 8'hc4 ^ 8'(m), 8'h96};
      u_spi_master_model.frame(3);
      chk("miso", 8'h31 + 8'(m), u_spi_master_model.rx_q[0]);
      chk("miso", 8'h84, u_spi_master_model.rx_q[1]);
      chk("fill", 8'h00, u_spi_master_model.rx_q[2]);
      pull(8'h1e);
      pull(8'hc4 ^ 8'(m));
      pull(8'h96);
      chk("attn off", {7'h00, !c.attn_active_high}, {7'h00, pins.attn});
    end
    $display("test modes done");
  endtask
  task automatic t_buffers();
    logic t;
    int got;
    got = 0;
    restart('0, 1'b0);
    for (int i = 0; i < 7; i++) begin
      push(8'h50 + 8'(i), t);
      got += int'(t);
    end
    tx_valid = 1'b0;
    chk("tx taken", 8'h05, 8'(got));
    ovr = 0;
    u_spi_master_model.tx_q = {8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
    u_spi_master_model.frame(7);
    for (int i = 0; i < 7; i++) begin
      chk("miso", i < 5 ? 8'h50 + 8'(i) : 8'h00, u_spi_master_model.rx_q[i]);
    end
    chk("overruns", 8'h02, 8'(ovr));
    for (int i = 0; i < 5; i++) pull(8'h10 + 8'(i));
    cyc(3);
    chk("rx empty", 8'h00, {7'h00, rx_valid});
    $display("test buffers done");
  endtask
  task automatic t_sleep();
    sleep_request = 1'b1;
    cyc(12);
    chk("asleep", 8'h01, {7'h00, link_asleep});
    // A frame from the master wakes the port; it falls asleep again afterwards
    u_spi_master_model.tx_q = {8'h5a};
    u_spi_master_model.frame(1);
    pull(8'h5a);
    cyc(6);
    chk("asleep again", 8'h01, {7'h00, link_asleep});
    sleep_request = 1'b0;
    cyc(3);
    chk("awake", 8'h00, {7'h00, link_asleep});
    $display("test sleep done");
  endtask
  task automatic t_strap();
    restart('0, 1'b1);
    chk("selected", 8'h00, {7'h00, spi_selected});
    u_spi_master_model.tx_q = {8'h77};
    u_spi_master_model.frame(1);
    cyc(5);
    chk("rx ignored", 8'h00, {7'h00, rx_valid});
    $display("test strap done");
  endtask
  initial begin
    miscompares = 0;
    n_tests = 0;
    ovr = 0;
    miso_last = 1'b0;
    rst_b = 1'b0;
    cfg = '0;
    strap_sel = 1'b0;
    sleep_request = 1'b0;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    t_modes();
    t_buffers();
    t_sleep();
    t_strap();
    summarize();
  end
endmodule
`default_nettype wire
